// ---- angle_avg_pkg.sv ----
// Constants shared by the angle averaging stage.
// Assumes a 10 MHz core clock; samples arrive one per sample slot.
package angle_avg_pkg;
	localparam int          ANGLE_BITS        = 12;
	localparam int          AVG_SEL_BITS      = 3;
	localparam int          CLK_HZ            = 10_000_000;
	localparam int          SLOT_US           = 25;
	localparam int          SLOT_CYCLES       = SLOT_US * (CLK_HZ / 1_000_000);
	localparam int          RESPONSE_US       = 60;
	localparam int          RESPONSE_CYCLES   = RESPONSE_US * (CLK_HZ / 1_000_000);
	localparam int          MAX_AVG_SHIFT     = 7;
	localparam logic [2:0]  AVG_SEL_RESET     = 3'h0;
	localparam logic [11:0] ANGLE_RESET       = 12'h000;
endpackage : angle_avg_pkg

// ---- sample_delay.sv ----
// Fixed latency line for one sample plus its strobe.
// Assumes strobes come at least DEPTH-1 cycles apart; a closer strobe drops the sample in flight.
`timescale 1ns/1ns
module sample_delay #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 600
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             ce,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data
);
	localparam int CW = $clog2(DEPTH + 1);
	logic [CW-1:0]    count;
	logic             busy;
	logic [WIDTH-1:0] held;
	// Output strobe registered one cycle early so the consumer writes DEPTH cycles after input
	wire              done = busy && (count == CW'(DEPTH - 2));

	always_ff @(posedge clk) begin
		if (!resetn) begin
			count     <= '0;
			busy      <= 1'b0;
			held      <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (ce) begin
			out_valid <= done;
			if (done) begin
				out_data <= held;
			end
			if (in_valid) begin
				held  <= in_data;
				busy  <= 1'b1;
				count <= '0;
			end else if (done) begin
				busy <= 1'b0;
			end else if (busy) begin
				count <= count + 1'b1;
			end
		end
	end
endmodule : sample_delay

// ---- angle_sample_averager.sv ----
// Averaging stage between the converter and the angle output register.
// Assumes samples arrive on sample_valid, one per 25 us slot, from the
// same clock domain; power_good and supply_low come from analog pins.
`timescale 1ns/1ns
module angle_sample_averager #(
	parameter int ANGLE_BITS = angle_avg_pkg::ANGLE_BITS,
	parameter int SLOT_CYC   = angle_avg_pkg::SLOT_CYCLES,
	parameter int RESP_CYC   = angle_avg_pkg::RESPONSE_CYCLES
) (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic                  ce,
	input  wire logic                  nv_fast_mode,
	input  wire logic [2:0]            nv_averaging_select,
	input  wire logic                  sample_valid,
	input  wire logic [ANGLE_BITS-1:0] sample_angle,
	input  wire logic                  power_good,
	input  wire logic                  supply_low,
	input  wire logic                  read_request,
	output logic      [ANGLE_BITS-1:0] angle_word,
	output logic                       angle_updated,
	output logic                       response_valid,
	output logic      [ANGLE_BITS:0]   response_word,
	output logic                       fast_mode,
	output logic      [2:0]            averaging_select,
	output logic                       ready
);
	localparam int SUM_BITS = ANGLE_BITS + angle_avg_pkg::MAX_AVG_SHIFT;
	localparam int WINDOWS  = 1 << angle_avg_pkg::AVG_SEL_BITS;
	// Fast path latency less one slot of front-end conversion
	localparam int PIPE_CYC = RESP_CYC - SLOT_CYC;

	typedef enum logic [1:0] {st_reset, st_load, st_run} state_t;
	state_t state;
	state_t next_state;

	// Pin synchronisers; only the second stage is read by logic
	logic pg_meta;
	logic pg_sync;
	logic sl_meta;
	logic sl_sync;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pg_meta <= 1'b0;
			pg_sync <= 1'b0;
		end else if (ce) begin
			pg_meta <= power_good;
			pg_sync <= pg_meta;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sl_meta <= 1'b0;
			sl_sync <= 1'b0;
		end else if (ce) begin
			sl_meta <= supply_low;
			sl_sync <= sl_meta;
		end
	end

	// Setup: one idle cycle, then the straps are caught once
	always_comb begin
		next_state = state;
		unique case (state)
			st_reset: next_state = st_load;
			st_load:  next_state = st_run;
			st_run:   next_state = st_run;
			default:  next_state = st_reset;
		endcase
	end

	// Straps are read only once, so later changes cannot disturb a window
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= st_reset;
		end else if (ce) begin
			state <= next_state;
		end
	end

	wire load_cfg = (state == st_load);
	wire running  = (state == st_run);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			fast_mode <= 1'b0;
		end else if (ce && load_cfg) begin
			fast_mode <= nv_fast_mode;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			averaging_select <= angle_avg_pkg::AVG_SEL_RESET;
		end else if (ce && load_cfg) begin
			averaging_select <= nv_averaging_select;
		end
	end

	// Window length less one for each select code
	logic [7:0] span_table [WINDOWS];
	genvar g;
	generate
		for (g = 0; g < WINDOWS; g++) begin : g_window
			assign span_table[g] = 8'((9'h001 << g) - 9'h001);
		end
	endgenerate
	wire [7:0] window_m1 = span_table[averaging_select];
	wire       bypass    = fast_mode || (averaging_select == 3'h0);

	// Fixed latency path for fast mode and select code 0; a fresh sample drops an older one in flight
	logic                  dly_valid;
	logic [ANGLE_BITS-1:0] dly_data;
	wire                   dly_in = sample_valid && running && bypass;

	sample_delay #(
		.WIDTH (ANGLE_BITS),
		.DEPTH (PIPE_CYC)
	) u_delay (
		.clk       (clk),
		.resetn    (resetn),
		.ce        (ce),
		.in_valid  (dly_in),
		.in_data   (sample_angle),
		.out_valid (dly_valid),
		.out_data  (dly_data)
	);

	// Accumulator for slow mode with a nonzero select code; wide enough for 128 full-scale samples
	logic [SUM_BITS-1:0]   sum;
	logic [7:0]            taken;
	wire                   acc_in     = sample_valid && running && !bypass;
	wire                   last       = acc_in && (taken == window_m1);
	wire [SUM_BITS-1:0]    sum_in     = SUM_BITS'(sample_angle);
	wire [SUM_BITS-1:0]    next_sum   = sum + sum_in;
	wire [7:0]             next_taken = taken + 8'h01;
	wire [SUM_BITS-1:0]    avg_full   = next_sum >> averaging_select;
	wire [ANGLE_BITS-1:0]  avg        = avg_full[ANGLE_BITS-1:0];

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sum <= '0;
		end else if (ce && last) begin
			sum <= '0;
		end else if (ce && acc_in) begin
			sum <= next_sum;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			taken <= 8'h00;
		end else if (ce && last) begin
			taken <= 8'h00;
		end else if (ce && acc_in) begin
			taken <= next_taken;
		end
	end

	// Output register; the two paths are never active in one mode
	wire                  update     = dly_valid || last;
	wire [ANGLE_BITS-1:0] next_angle = dly_valid ? dly_data : avg;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			angle_word <= angle_avg_pkg::ANGLE_RESET;
		end else if (ce && update) begin
			angle_word <= next_angle;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			angle_updated <= 1'b0;
		end else if (ce) begin
			angle_updated <= update;
		end
	end

	// Reads refused until setup ends and supply has been good two edges
	wire take_read = read_request && ready;
	assign ready = running && pg_sync;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			response_valid <= 1'b0;
		end else if (ce) begin
			response_valid <= take_read;
		end
	end

	// Flag and angle caught together so one read sees a matching pair
	always_ff @(posedge clk) begin
		if (!resetn) begin
			response_word <= '0;
		end else if (ce && take_read) begin
			response_word <= {sl_sync, angle_word};
		end
	end
endmodule : angle_sample_averager

// ---- angle_avg_sva.sv ----
// Port checker for the angle averaging stage.
// Bound to the design; assumes ce stays high while samples flow.
`timescale 1ns/1ns
module angle_avg_sva #(
	parameter int SLOT_CYC = 10,
	parameter int RESP_CYC = 24
) (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        ce,
	input wire logic        sample_valid,
	input wire logic [11:0] sample_angle,
	input wire logic        power_good,
	input wire logic        supply_low,
	input wire logic        read_request,
	input wire logic [11:0] angle_word,
	input wire logic        angle_updated,
	input wire logic        response_valid,
	input wire logic [12:0] response_word,
	input wire logic        fast_mode,
	input wire logic [2:0]  averaging_select,
	input wire logic        ready
);
	localparam int P  = RESP_CYC - SLOT_CYC;
	localparam int PW = P + 1;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	upd_pulse_a: assert property (angle_updated |=> !angle_updated) else $error("long pulse");
	upd_tie_a: assert property ($changed(angle_word) |-> angle_updated) else $error("no pulse");
	resp_take_a: assert property (read_request && ready |=> response_valid
		&& response_word[11:0] == $past(angle_word)) else $error("bad response");
	resp_only_a: assert property (response_valid |-> $past(read_request && ready))
		else $error("stray response");
	low_flag_a: assert property ($stable(supply_low)[*6] ##0 response_valid
		|-> response_word[12] == supply_low) else $error("bad flag");
	pg_gate_a: assert property (!power_good[*3] |-> !ready) else $error("ready early");
	cfg_hold_a: assert property (resetn[*5] |-> $stable({fast_mode, averaging_select}))
		else $error("config moved");
	fast_pipe_a: assert property (sample_valid && ce && ready && (fast_mode
		|| averaging_select == 3'h0) |-> ##PW angle_word == $past(sample_angle, PW)
		&& angle_updated) else $error("fast path late");
	cover property (response_valid);
	cover property (angle_updated && averaging_select == 3'h7);
	cover property (read_request && !ready);
endmodule : angle_avg_sva
bind angle_sample_averager angle_avg_sva #(.SLOT_CYC(SLOT_CYC), .RESP_CYC(RESP_CYC)) sva (.*);

// ---- host_reader.sv ----
// Host that polls the angle response port.
// Assumes go is a one-cycle request from the bench.
`timescale 1ns/1ns
module host_reader (
	input  wire logic        clk,
	input  wire logic        go,
	input  wire logic        response_valid,
	input  wire logic [12:0] response_word,
	output logic             read_request = 1'b0,
	output logic [12:0]      word = 13'h0000,
	output logic             got = 1'b0
);
	always @(posedge clk) begin
		read_request <= go;
		got <= response_valid;
		if (response_valid) begin
			word <= response_word;
		end
	end
endmodule : host_reader

// ---- testbench.sv ----
// Self-checking bench for the angle averaging stage.
// Shortened slot and pipe counts; inputs move 5 ns after each rising edge.
`timescale 1ns/1ns
module testbench;
	logic clk, resetn, ce, nv_fast_mode, sample_valid, power_good, supply_low, go, got;
	logic angle_updated, response_valid, fast_mode, ready, read_request;
	logic [2:0] nv_averaging_select, averaging_select;
	logic [11:0] sample_angle, angle_word, e;
	logic [12:0] response_word, word;
	logic [11:0] rows [9] = '{12'h001, 12'h102, 12'h204, 12'h308, 12'h410, 12'h520,
		12'h640, 12'h780, 12'hd01};
	int failures, checked;
	angle_sample_averager #(.SLOT_CYC(10), .RESP_CYC(24)) DUT (.*);
	host_reader host (.*);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic tick;
		@(posedge clk);
		#5;
	endtask : tick
	task automatic chk(input logic [12:0] s, input logic [12:0] x);
		checked++;
		if (s !== x) begin
			failures++;
			$display("[FAIL] %0t seen %h want %h", $time, s, x);
		end
	endtask : chk
	task automatic feed(input int n, input int b);
		int s, u;
		s = 0;
		u = 0;
		for (int i = 0; i < n; i++) begin
			sample_angle = 12'(b + i * 3);
			sample_valid = 1'b1;
			s += b + i * 3;
			tick;
			sample_valid = 1'b0;
			repeat (19) begin
				u += int'(angle_updated);
				tick;
			end
		end
		e = 12'(s / n);
		chk(13'(u), 13'h0001);
		chk({1'b0, angle_word}, {1'b0, e});
	endtask : feed
	task automatic end_sim;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		{resetn, sample_valid, go, supply_low, nv_fast_mode} = 5'h00;
		{ce, power_good, nv_averaging_select, sample_angle} = 17'h18000;
		failures = 0;
		checked = 0;
		foreach (rows[r]) begin
			resetn = 1'b0;
			{nv_fast_mode, nv_averaging_select} = rows[r][11:8];
			repeat (3) tick;
			chk({1'b0, angle_word}, 13'h0000);
			resetn = 1'b1;
			repeat (4) tick;
			chk({9'h000, fast_mode, averaging_select}, {9'h000, rows[r][11:8]});
			feed(int'(rows[r][7:0]), 'h100);
			feed(int'(rows[r][7:0]), 'h240);
		end
		supply_low = 1'b1;
		repeat (8) tick;
		go = 1'b1;
		tick;
		go = 1'b0;
		repeat (3) tick;
		chk(word, {1'b1, e});
		power_good = 1'b0;
		repeat (4) tick;
		chk({12'h000, ready}, 13'h0000);
		go = 1'b1;
		tick;
		go = 1'b0;
		repeat (3) begin
			chk({12'h000, got}, 13'h0000);
			tick;
		end
		power_good = 1'b1;
		repeat (4) tick;
		chk({12'h000, ready}, 13'h0001);
		end_sim;
	end
endmodule : testbench
